// [hw/nand_host_ctrl.sv]
// apb-controlled host for a multiplexed 8-bit nand flash
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
module nand_host_ctrl #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic select_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic input_strobe_n,
  output logic output_strobe_n,
  output logic write_guard_n,
  output logic powerup_protect,
  output logic [7:0] shared_byte_bus_out,
  output logic shared_byte_bus_oe,
  input wire logic [7:0] shared_byte_bus_in,
  input wire logic ready_busy_n
);

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_SINGLE = 5'b00010,
    S_MACRO = 5'b00100,
    S_ONSET = 5'b01000,
    S_WAIT_READY = 5'b10000
  } seq_state_t;

  nand_cycle_if cyc ();

  seq_state_t state;
  logic [2:0] ctrl;
  logic [27:0] page_addr;
  logic [7:0] rdata;
  logic [15:0] read_count;
  logic refused;
  logic [2:0] step;
  logic [7:0] onset_cnt;
  logic single_read;
  logic wr_en;
  logic rd_sel;
  logic mapped;
  logic busy;
  logic cmd_wr;
  logic [2:0] step_up;
  logic [7:0] next_step_byte;
  nand_host_pkg::kind_t next_step_kind;

  // zero-wait slave: the access phase completes on its first edge
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_sel = psel && !pwrite;
  assign busy = (state != S_IDLE);
  assign step_up = step + 3'h1;
  assign cmd_wr = wr_en && (paddr[11:0] == nand_host_pkg::CMD_OFS);

  // address decode for mapped words
  always_comb
  begin
    unique case (paddr[11:0])
      nand_host_pkg::CTRL_OFS,
      nand_host_pkg::CMD_OFS,
      nand_host_pkg::ADDR_OFS,
      nand_host_pkg::STATUS_OFS,
      nand_host_pkg::RDATA_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  // read data mux, unmapped words read as zero
  always_comb
  begin
    prdata = 32'h00000000;
    if (rd_sel)
    begin
      unique case (paddr[11:0])
        nand_host_pkg::CTRL_OFS: prdata = {29'h0, ctrl};
        nand_host_pkg::ADDR_OFS: prdata = {4'h0, page_addr};
        nand_host_pkg::STATUS_OFS: prdata = {29'h0, refused, ready_busy_n, busy};
        nand_host_pkg::RDATA_OFS: prdata = {read_count, 8'h00, rdata};
        default: prdata = 32'h00000000;
      endcase
    end
  end

  // control register: select, write guard and protection strap levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= nand_host_pkg::CTRL_RESET;
    else if (wr_en && paddr[11:0] == nand_host_pkg::CTRL_OFS)
      ctrl <= pwdata[2:0];
  end

  // pins steered by the control register
  assign select_n = !ctrl[nand_host_pkg::CTRL_SELECT_BIT];
  assign write_guard_n = ctrl[nand_host_pkg::CTRL_GUARD_BIT];
  assign powerup_protect = ctrl[nand_host_pkg::CTRL_PROTECT_BIT];

  // page address, column in the low 12 bits, row above
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      page_addr <= nand_host_pkg::ADDR_RESET;
    else if (wr_en && paddr[11:0] == nand_host_pkg::ADDR_OFS)
      page_addr <= pwdata[27:0];
  end

  // sticky flag: command written while busy; set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      refused <= 1'b0;
    else if (cmd_wr && busy)
      refused <= 1'b1;
    else if (wr_en && paddr[11:0] == nand_host_pkg::STATUS_OFS
             && pwdata[nand_host_pkg::STATUS_REFUSED_BIT])
      refused <= 1'b0;
  end

  // byte and kind of the step that follows the current one
  always_comb
  begin
    next_step_byte = nand_host_pkg::PAGE_READ_OPEN;
    next_step_kind = nand_host_pkg::KIND_ADDR;
    unique case (step_up)
      3'h0:
      begin
        next_step_byte = nand_host_pkg::PAGE_READ_OPEN;
        next_step_kind = nand_host_pkg::KIND_CMD;
      end
      3'h1: next_step_byte = page_addr[7:0];
      3'h2: next_step_byte = {4'h0, page_addr[11:8]};
      3'h3: next_step_byte = page_addr[19:12];
      3'h4: next_step_byte = page_addr[27:20];
      3'h5:
      begin
        next_step_byte = nand_host_pkg::PAGE_READ_CONFIRM;
        next_step_kind = nand_host_pkg::KIND_CMD;
      end
      default:
      begin
        next_step_byte = 8'h00;
        next_step_kind = nand_host_pkg::KIND_CMD;
      end
    endcase
  end

  // sequencer: single cycles or the page read sequence then busy wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_IDLE;
      step <= 3'h0;
      onset_cnt <= 8'h00;
      single_read <= 1'b0;
    end
    else
    begin
      unique case (state)
        S_IDLE:
        begin
          if (cmd_wr)
          begin
            step <= 3'h0;
            single_read <= (pwdata[9:8] == nand_host_pkg::KIND_RDATA);
            state <= pwdata[nand_host_pkg::CMD_MACRO_BIT] ? S_MACRO : S_SINGLE;
          end
        end
        S_SINGLE:
        begin
          if (cyc.done)
            state <= S_IDLE;
        end
        S_MACRO:
        begin
          if (cyc.done)
          begin
            if (step == 3'(nand_host_pkg::PAGE_READ_STEPS - 1))
            begin
              state <= S_ONSET;
              onset_cnt <= 8'(nand_host_pkg::BUSY_ONSET_CYC - 1);
            end
            else
              step <= step + 3'h1;
          end
        end
        S_ONSET:
        begin
          // device needs a moment to pull the ready line low
          if (onset_cnt == 8'h00)
            state <= S_WAIT_READY;
          else
            onset_cnt <= onset_cnt - 8'h01;
        end
        S_WAIT_READY:
        begin
          if (ready_busy_n)
            state <= S_IDLE;
        end
      endcase
    end
  end

  // engine requests: one pulse per byte cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyc.req <= 1'b0;
      cyc.kind <= nand_host_pkg::KIND_CMD;
      cyc.wbyte <= 8'h00;
    end
    else if (state == S_IDLE && cmd_wr && pwdata[nand_host_pkg::CMD_MACRO_BIT])
    begin
      // sequence opens with its read command at once
      cyc.req <= 1'b1;
      cyc.kind <= nand_host_pkg::KIND_CMD;
      cyc.wbyte <= nand_host_pkg::PAGE_READ_OPEN;
    end
    else if (state == S_IDLE && cmd_wr)
    begin
      cyc.req <= 1'b1;
      cyc.kind <= nand_host_pkg::kind_t'(pwdata[9:8]);
      cyc.wbyte <= pwdata[7:0];
    end
    else if (state == S_MACRO && cyc.done
             && step != 3'(nand_host_pkg::PAGE_READ_STEPS - 1))
    begin
      // next byte issued on the edge the previous cycle reports done
      cyc.req <= 1'b1;
      cyc.kind <= next_step_kind;
      cyc.wbyte <= next_step_byte;
    end
    else
      cyc.req <= 1'b0;
  end

  // last byte read from the device and count of bytes read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata <= 8'h00;
      read_count <= 16'h0000;
    end
    else if (state == S_SINGLE && cyc.done && single_read)
    begin
      rdata <= cyc.rbyte;
      read_count <= read_count + 16'h0001;
    end
  end

  nand_cycle_engine engine (
    .pclk(pclk),
    .presetn(presetn),
    .cyc(cyc),
    .cmd_latch(cmd_latch),
    .addr_latch(addr_latch),
    .input_strobe_n(input_strobe_n),
    .output_strobe_n(output_strobe_n),
    .bus_out(shared_byte_bus_out),
    .bus_oe(shared_byte_bus_oe),
    .bus_in(shared_byte_bus_in)
  );

endmodule : nand_host_ctrl

// [hw/nand_host_pkg.sv]
// shared constants and types for the nand flash host controller
package nand_host_pkg;

  // clock rate and pin timing, times in ns as figures, counts derived
  localparam int CLK_MHZ = 100;
  localparam int STROBE_LOW_NS = 25;
  localparam int STROBE_HIGH_NS = 15;
  localparam int OUTPUT_ACCESS_DELAY_NS = 20;
  localparam int BUSY_ONSET_NS = 100;
  // least times round up to whole cycles
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int ACCESS_CYC = (OUTPUT_ACCESS_DELAY_NS * CLK_MHZ + 999) / 1000 + 1;
  localparam int BUSY_ONSET_CYC = (BUSY_ONSET_NS * CLK_MHZ + 999) / 1000;

  // register byte offsets on apb
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] CMD_OFS = 12'h004;
  localparam logic [11:0] ADDR_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00C;
  localparam logic [11:0] RDATA_OFS = 12'h010;

  // field positions
  localparam int CTRL_SELECT_BIT = 0;
  localparam int CTRL_GUARD_BIT = 1;
  localparam int CTRL_PROTECT_BIT = 2;
  localparam int CMD_KIND_LSB = 8;
  localparam int CMD_MACRO_BIT = 10;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_READY_BIT = 1;
  localparam int STATUS_REFUSED_BIT = 2;

  // values after reset
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [27:0] ADDR_RESET = 28'h0000000;

  // page read opening and confirm command bytes
  localparam logic [7:0] PAGE_READ_OPEN = 8'h00;
  localparam logic [7:0] PAGE_READ_CONFIRM = 8'h30;
  localparam int PAGE_READ_STEPS = 6;

  // kind of one bus cycle on the pins
  typedef enum logic [1:0] {
    KIND_CMD = 2'h0,
    KIND_ADDR = 2'h1,
    KIND_WDATA = 2'h2,
    KIND_RDATA = 2'h3
  } kind_t;

endpackage : nand_host_pkg

// [hw/nand_cycle_if.sv]
// request and answer signals between sequencer and pin cycle engine
`timescale 1ns/10ps
interface nand_cycle_if;
  logic req;
  nand_host_pkg::kind_t kind;
  logic [7:0] wbyte;
  logic done;
  logic [7:0] rbyte;

  modport seq (output req, output kind, output wbyte, input done, input rbyte);
  modport eng (input req, input kind, input wbyte, output done, output rbyte);
endinterface : nand_cycle_if

// [hw/nand_cycle_engine.sv]
// one strobed byte cycle on the flash pins
`timescale 1ns/10ps
module nand_cycle_engine (
  input wire logic pclk,
  input wire logic presetn,
  nand_cycle_if.eng cyc,
  output logic cmd_latch,
  output logic addr_latch,
  output logic input_strobe_n,
  output logic output_strobe_n,
  output logic [7:0] bus_out,
  output logic bus_oe,
  input wire logic [7:0] bus_in
);

  typedef enum logic [3:0] {
    E_IDLE = 4'b0001,
    E_SETUP = 4'b0010,
    E_LOW = 4'b0100,
    E_HIGH = 4'b1000
  } eng_state_t;

  eng_state_t state;
  logic [7:0] cnt;
  logic is_read;

  // cycle sequencing: setup, strobe low, strobe high recovery
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= E_IDLE;
      cnt <= 8'h00;
      is_read <= 1'b0;
    end
    else
    begin
      unique case (state)
        E_IDLE:
        begin
          if (cyc.req)
          begin
            state <= E_SETUP;
            is_read <= (cyc.kind == nand_host_pkg::KIND_RDATA);
          end
        end
        E_SETUP:
        begin
          state <= E_LOW;
          cnt <= is_read ? 8'(nand_host_pkg::ACCESS_CYC - 1)
                         : 8'(nand_host_pkg::STROBE_LOW_CYC - 1);
        end
        E_LOW:
        begin
          if (cnt == 8'h00)
          begin
            state <= E_HIGH;
            cnt <= 8'(nand_host_pkg::STROBE_HIGH_CYC - 1);
          end
          else
            cnt <= cnt - 8'h01;
        end
        E_HIGH:
        begin
          if (cnt == 8'h00)
            state <= E_IDLE;
          else
            cnt <= cnt - 8'h01;
        end
      endcase
    end
  end

  // latch lines and driven byte, set up before the strobe falls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      bus_out <= 8'h00;
      bus_oe <= 1'b0;
    end
    else if (state == E_IDLE && cyc.req)
    begin
      cmd_latch <= (cyc.kind == nand_host_pkg::KIND_CMD);
      addr_latch <= (cyc.kind == nand_host_pkg::KIND_ADDR);
      bus_out <= cyc.wbyte;
      bus_oe <= (cyc.kind != nand_host_pkg::KIND_RDATA);
    end
    else if (state == E_HIGH && cnt == 8'h00)
    begin
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      bus_oe <= 1'b0;
    end
  end

  // strobes: input strobe for written bytes, output strobe for reads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
    end
    else if (state == E_SETUP)
    begin
      input_strobe_n <= is_read;
      output_strobe_n <= !is_read;
    end
    else if (state == E_LOW && cnt == 8'h00)
    begin
      input_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
    end
  end

  // read byte taken after the access delay, before the strobe rises
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cyc.rbyte <= 8'h00;
    else if (state == E_LOW && cnt == 8'h00 && is_read)
      cyc.rbyte <= bus_in;
  end

  // one-cycle done at the end of recovery
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cyc.done <= 1'b0;
    else
      cyc.done <= (state == E_HIGH && cnt == 8'h00);
  end

endmodule : nand_cycle_engine

// [test/nand_host_ctrl_properties.sv]
// concurrent checks on the flash pins of the host controller
`timescale 1ns/10ps
module nand_host_ctrl_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic input_strobe_n,
  input wire logic output_strobe_n,
  input wire logic write_guard_n,
  input wire logic powerup_protect,
  input wire logic [7:0] shared_byte_bus_out,
  input wire logic shared_byte_bus_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // latch and strobe exclusivity
  latch_exclusive_a: assert property (!(cmd_latch && addr_latch))
    else $error("both latches high");
  strobe_exclusive_a: assert property (input_strobe_n || output_strobe_n)
    else $error("both strobes low");
  // bus direction follows the strobe in use
  write_drives_a: assert property (!input_strobe_n |-> shared_byte_bus_oe)
    else $error("write strobe low with bus released");
  read_releases_a: assert property (!output_strobe_n |-> !shared_byte_bus_oe)
    else $error("read strobe low with bus driven");
  byte_setup_a: assert property ($fell(input_strobe_n) |-> $past(shared_byte_bus_oe))
    else $error("byte not set up before strobe");
  // pulse widths and recovery
  write_width_a: assert property ($fell(input_strobe_n) |->
    (!input_strobe_n)[*3] ##1 input_strobe_n) else $error("write strobe width wrong");
  read_width_a: assert property ($fell(output_strobe_n) |->
    (!output_strobe_n)[*3] ##1 output_strobe_n) else $error("read strobe width wrong");
  strobe_recover_a: assert property (($rose(input_strobe_n) || $rose(output_strobe_n)) |->
    (input_strobe_n && output_strobe_n)[*3]) else $error("strobe high phase too short");
  byte_steady_a: assert property (!input_strobe_n |-> $stable(shared_byte_bus_out) &&
    $stable(cmd_latch) && $stable(addr_latch)) else $error("byte changed under strobe");
  guard_reset_a: assert property (!$past(presetn) |-> !write_guard_n && !powerup_protect)
    else $error("guard not low after reset");

  // main kinds of pin cycle
  cover property (!input_strobe_n && cmd_latch);
  cover property (!input_strobe_n && addr_latch);
  cover property (!input_strobe_n && !cmd_latch && !addr_latch);
  cover property ($fell(output_strobe_n));
endmodule : nand_host_ctrl_properties

bind nand_host_ctrl nand_host_ctrl_properties i_nand_host_ctrl_properties (
  .pclk(pclk), .presetn(presetn), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
  .input_strobe_n(input_strobe_n), .output_strobe_n(output_strobe_n),
  .write_guard_n(write_guard_n), .powerup_protect(powerup_protect),
  .shared_byte_bus_out(shared_byte_bus_out), .shared_byte_bus_oe(shared_byte_bus_oe));

// [test/nand_flash_model.sv]
// behavioural flash device answering the host pins
`timescale 1ns/10ps
module nand_flash_model #(
  parameter int FETCH_NS = 25000,
  parameter int PROG_NS = 300000,
  parameter int ACCESS_NS = 20,
  parameter int CACHE_NS = 3000
) (
  input wire logic select_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic input_strobe_n,
  input wire logic output_strobe_n,
  input wire logic write_guard_n,
  input wire logic powerup_protect,
  input wire logic [7:0] bus,
  output logic [7:0] dq,
  output logic ready_busy_n
);
  logic [7:0] page [0:2111];
  logic [31:0] addr = 32'h00000000;
  logic [11:0] col = 12'h000;
  logic [11:0] rcol = 12'h000;
  logic [7:0] last_cmd = 8'h00;
  logic [1:0] nadr = 2'h0;
  logic locked = 1'b0;
  logic standby = 1'b0;
  int ncmd = 0;
  int k;

  // strap sampled once at power-on
  initial
  begin
    dq = 8'h5A;
    ready_busy_n = 1'b1;
    // taken after the host reset settles; floating counts as low
    #20 locked = (powerup_protect === 1'b1);
  end

  // open-drain ready line pulled low for a span, select ignored meanwhile
  task automatic hold_busy(input int ns);
    ready_busy_n = 1'b0;
    #(ns);
    ready_busy_n = 1'b1;
  endtask : hold_busy

  // bytes taken at the input strobe rise while selected
  always @(posedge input_strobe_n)
  begin
    if (!select_n && cmd_latch)
    begin
      last_cmd = bus;
      ncmd++;
      nadr = 2'h0;
      if (bus == 8'h30)
      begin
        for (k = 0; k < 2112; k++)
          page[k] = {addr[23:22], addr[21:16]} ^ k[7:0]; // block over page bits
        col = addr[11:0];
        hold_busy(FETCH_NS);
      end
      if (bus == 8'h10 && write_guard_n && !locked)
        hold_busy(PROG_NS);
      if (bus == 8'h31)
      begin
        col = 12'h000;
        hold_busy(CACHE_NS);
      end
    end
    else if (!select_n && addr_latch)
    begin
      addr[nadr*8 +: 8] = bus;
      col = addr[11:0];
      nadr++;
    end
    else if (!select_n)
    begin
      page[col] = bus;
      col++;
    end
  end

  // column advances on the fall, byte appears after the access delay
  always @(negedge output_strobe_n)
  begin
    if (!select_n)
    begin
      rcol = col;
      col++;
      dq = ~dq;
      #(ACCESS_NS) dq = page[rcol];
    end
  end

  // released bus shows a changed pattern, never the last byte
  always @(posedge output_strobe_n)
    #5 dq = ~dq;

  // leaving select while idle gives standby
  always @(posedge select_n)
    standby = ready_busy_n;
endmodule : nand_flash_model

// [test/test_nand_host_ctrl.sv]
// self-checking bench for the apb nand flash host controller
`timescale 1ns/10ps
module test_nand_host_ctrl;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic select_n;
  logic cmd_latch;
  logic addr_latch;
  logic input_strobe_n;
  logic output_strobe_n;
  logic write_guard_n;
  logic powerup_protect;
  logic [7:0] bus_out;
  logic bus_oe;
  logic [7:0] dq;
  logic ready_busy_n;
  logic [31:0] rd;
  logic err;
  logic low_seen;
  logic [31:0] seed = 32'h0000AD1F;
  logic [31:0] a;
  logic [7:0] wb [0:3];
  int errors = 0;
  int comparisons = 0;
  int n;
  int i;
  // host drive wins, otherwise the device pattern
  wire [7:0] bus_in = bus_oe ? bus_out : dq;

  always #5 pclk = ~pclk;

  nand_host_ctrl i_nand_host_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .select_n(select_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .input_strobe_n(input_strobe_n), .output_strobe_n(output_strobe_n),
    .write_guard_n(write_guard_n), .powerup_protect(powerup_protect),
    .shared_byte_bus_out(bus_out), .shared_byte_bus_oe(bus_oe),
    .shared_byte_bus_in(bus_in), .ready_busy_n(ready_busy_n));
  nand_flash_model #(.FETCH_NS(2000), .PROG_NS(3000)) i_nand_flash_model (
    .select_n(select_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .input_strobe_n(input_strobe_n), .output_strobe_n(output_strobe_n),
    .write_guard_n(write_guard_n), .powerup_protect(powerup_protect), .bus(bus_in),
    .dq(dq), .ready_busy_n(ready_busy_n));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // content the device loads for a page
  function automatic logic [7:0] fill(input logic [31:0] ad, input int k);
    return ad[23:16] ^ 8'(k);
  endfunction : fill

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // write the trigger word and poll until idle, noting the ready line
  task automatic order(input logic [31:0] w);
    apb(1'b1, nand_host_pkg::CMD_OFS, w);
    low_seen = 1'b0;
    do
    begin
      apb(1'b0, nand_host_pkg::STATUS_OFS, 32'h00000000);
      low_seen = low_seen | (rd[1] === 1'b0);
    end
    while (rd[0] !== 1'b0);
  endtask : order

  task automatic send_addr(input logic [31:0] ad);
    for (int j = 0; j < 4; j++)
      order({22'h000000, nand_host_pkg::KIND_ADDR, ad[j*8 +: 8]});
  endtask : send_addr

  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // cut a hang well beyond the expected run
  initial
  begin
    #200000;
    errors++;
    conclude();
  end

  // main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    check({select_n, write_guard_n, powerup_protect}, 3'h4);
    apb(1'b0, 12'h7F0, 32'h00000000);
    check({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, nand_host_pkg::CTRL_OFS, 32'h00000003);
    // random odd command bytes, none starts an operation
    for (n = 0; n < 3; n++)
    begin
      seed = lfsr(seed);
      order({22'h000000, nand_host_pkg::KIND_CMD, 1'b1, seed[7:2], 1'b1});
      check(i_nand_flash_model.last_cmd, {1'b1, seed[7:2], 1'b1});
    end
    // address, data into the buffer, then the same bytes read back
    a = {seed[31:16], 5'h00, seed[10:0]};
    send_addr(a);
    check(i_nand_flash_model.addr, a);
    for (n = 0; n < 4; n++)
    begin
      seed = lfsr(seed);
      wb[n] = seed[7:0];
      order({22'h000000, nand_host_pkg::KIND_WDATA, wb[n]});
      check(i_nand_flash_model.page[a[11:0] + n], wb[n]);
    end
    send_addr(a);
    for (n = 0; n < 4; n++)
    begin
      order({22'h000000, nand_host_pkg::KIND_RDATA, 8'h00});
      apb(1'b0, nand_host_pkg::RDATA_OFS, 32'h00000000);
      check(rd, {16'(n + 1), 8'h00, wb[n]});
    end
    // deselected device ignores a command; a request while busy is refused
    apb(1'b1, nand_host_pkg::CTRL_OFS, 32'h00000002);
    i = i_nand_flash_model.ncmd;
    apb(1'b1, nand_host_pkg::CMD_OFS, 32'h00000001);
    order(32'h00000001);
    check(i_nand_flash_model.ncmd, i);
    check(rd[2], 1'b1);
    apb(1'b1, nand_host_pkg::STATUS_OFS, 32'h00000004);
    apb(1'b0, nand_host_pkg::STATUS_OFS, 32'h00000000);
    check(rd[2], 1'b0);
    // program start with guard low, then high
    for (n = 0; n < 2; n++)
    begin
      apb(1'b1, nand_host_pkg::CTRL_OFS, n ? 32'h00000003 : 32'h00000001);
      order(32'h00000080);
      order(32'h00000010);
      apb(1'b0, nand_host_pkg::STATUS_OFS, 32'h00000000);
      check(rd[1], n == 0);
      while (rd[1] !== 1'b1)
        apb(1'b0, nand_host_pkg::STATUS_OFS, 32'h00000000);
    end
    // page read sequence, random column then the last four bytes
    for (n = 0; n < 2; n++)
    begin
      seed = lfsr(seed);
      a = {seed[31:16], 4'h0, n ? 12'h83C : {1'b0, seed[10:0]}};
      apb(1'b1, nand_host_pkg::ADDR_OFS, {4'h0, a[31:16], a[11:0]});
      i = i_nand_flash_model.ncmd;
      order(32'h00000400);
      check({low_seen, i_nand_flash_model.last_cmd}, {1'b1, 8'h30});
      check(i_nand_flash_model.ncmd, i + 2);
      check(i_nand_flash_model.addr, a);
      for (i = 0; i < 4; i++)
      begin
        order({22'h000000, nand_host_pkg::KIND_RDATA, 8'h00});
        apb(1'b0, nand_host_pkg::RDATA_OFS, 32'h00000000);
        check(rd[7:0], fill(a, a[11:0] + i));
      end
    end
    conclude();
  end
endmodule : test_nand_host_ctrl
